// ==== inc/pepcr_pkg.sv ====
// Package for the extended page 2 control and status register bank
package pepcr_pkg;

    // ------------------------------------------------------------------
    // Management register numbers
    // ------------------------------------------------------------------
    localparam logic [4:0]  PEPCR_ADDR_TX_TRIM  = 5'h10;
    localparam logic [4:0]  PEPCR_ADDR_EEE_CTL  = 5'h11;
    localparam logic [4:0]  PEPCR_ADDR_MAC_IF   = 5'h14;
    localparam logic [4:0]  PEPCR_ADDR_WAKE_LO  = 5'h15;
    localparam logic [4:0]  PEPCR_ADDR_PAGE     = 5'h1F;
    localparam logic [4:0]  PEPCR_PAGED_FIRST   = 5'h10;
    localparam logic [4:0]  PEPCR_PAGED_LAST    = 5'h1E;

    // ------------------------------------------------------------------
    // Page selector values
    // ------------------------------------------------------------------
    localparam logic [15:0] PEPCR_PAGE_EXT2     = 16'h0002;
    localparam logic [15:0] PEPCR_PAGE_MAIN     = 16'h0000;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] PEPCR_TRIM_RST      = 16'h028E;
    localparam logic [15:0] PEPCR_TRIM_MASK     = 16'h0FFF;
    localparam logic [15:0] PEPCR_EEE_RST       = 16'h0000;
    localparam logic [15:0] PEPCR_EEE_MASK      = 16'h8C1C;
    localparam logic [15:0] PEPCR_MAC_RST       = 16'h0000;
    localparam logic [15:0] PEPCR_MAC_STK_MASK  = 16'h10FF;
    localparam logic [15:0] PEPCR_WAKE_RST      = 16'h0000;
    localparam logic [15:0] PEPCR_WAKE_MASK     = 16'hFFFF;
    localparam logic [15:0] PEPCR_ZERO16        = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PEPCR_TRIM_TX100_LSB = 8;
    localparam int PEPCR_TRIM_T10_LSB   = 4;
    localparam int PEPCR_TRIM_TE10_LSB  = 0;
    localparam int PEPCR_EEE_TE10_BIT   = 15;
    localparam int PEPCR_EEE_LED_LSB    = 10;
    localparam int PEPCR_EEE_LINK_BIT   = 8;
    localparam int PEPCR_EEE_EN100_BIT  = 6;
    localparam int PEPCR_EEE_FLPI_BIT   = 4;
    localparam int PEPCR_EEE_INHTX_BIT  = 3;
    localparam int PEPCR_EEE_INHRX_BIT  = 2;
    localparam int PEPCR_MAC_FFAIL_BIT  = 15;
    localparam int PEPCR_MAC_SOF_BIT    = 12;
    localparam int PEPCR_MAC_RXREV_BIT  = 7;
    localparam int PEPCR_MAC_RXDLY_LSB  = 4;
    localparam int PEPCR_MAC_TXREV_BIT  = 3;
    localparam int PEPCR_MAC_TXDLY_LSB  = 0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       lpi;    // Low-power idle indication
        logic [3:0] data;   // Nibble data lines
    } pepcr_lane_s;

    typedef struct packed {
        logic [3:0]  trimTx100;
        logic [3:0]  trimT10;
        logic [3:0]  trimTe10;
        logic        eeeTe10En;
        logic [1:0]  ledInvert;
        logic        fastLinkFailV2En;
        logic        sofEn;
        logic [2:0]  rxClkDelay;
        logic [2:0]  txClkDelay;
        logic [15:0] wakeAddrLow;
    } pepcr_cfg_s;

endpackage

// ==== design/pepcr_sync.sv ====
// Two-stage synchroniser for the asynchronous status inputs
`timescale 1ns/1ns
module pepcr_sync
    import pepcr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [1:0] asyncIn,
    output logic      [1:0] syncOut
);

    logic [1:0] stage1_r;
    logic [1:0] stage2_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stage1_r <= 2'h0;
            stage2_r <= 2'h0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;

endmodule

// ==== design/pepcr_lane_map.sv ====
// Registered nibble lane with optional bit-order reversal
`timescale 1ns/1ns
module pepcr_lane_map
    import pepcr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        reverse,
    input  wire pepcr_lane_s laneIn,
    output pepcr_lane_s      laneOut
);

    pepcr_lane_s lane_r;
    pepcr_lane_s lane_nxt;

    // Swap bit 3 with bit 0 and bit 2 with bit 1
    function automatic logic [3:0] flipNibble(input logic [3:0] n);
        flipNibble = {n[0], n[1], n[2], n[3]};
    endfunction

    // Select natural or reversed order
    always_comb begin
        lane_nxt      = laneIn;
        lane_nxt.data = reverse ? flipNibble(laneIn.data) : laneIn.data;
    end

    // Register the lane
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lane_r <= '0;
        end else begin
            lane_r <= lane_nxt;
        end
    end

    assign laneOut = lane_r;

endmodule

// ==== design/pepcr_regs.sv ====
// Extended page 2 control and status registers with MAC lane handling
//
// Functional notes
// - 100BASE-TX trim bits 11:8, reset 0010
// - 10BASE-T trim bits 7:4, reset 1000
// - 10BASE-Te trim bits 3:0, reset 1110
// - Energy-efficient 10BASE-Te enable bit 15
// - LED polarity invert bits 11:10, reset 00
// - Read-only link and EEE100 status bits
// - Force LPI on line, discard MAC data
// - Inhibit transmit LPI in 100BASE-TX
// - Inhibit receive LPI to MAC in 100BASE-TX
// - Non-sticky fast link fail v2 enable
// - Sticky start-of-frame indication enable bit 12
// - Receive nibble reversal when bit 7 set
// - Transmit nibble reversal when bit 3 set
// - Three-bit receive and transmit clock delay selects
// - Sticky wake address low word
// - Visible at 16-30 only on page 2
`timescale 1ns/1ns
module pepcr_regs
    import pepcr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        softRst,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdData,
    input  wire logic        linkUpPin,
    input  wire logic        eee100Pin,
    input  wire logic        speed100,
    input  wire pepcr_lane_s macTx,
    input  wire pepcr_lane_s lineRx,
    output pepcr_lane_s      lineTx,
    output pepcr_lane_s      macRx,
    output pepcr_cfg_s       cfg,
    output logic      [15:0] pageSel
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // True when the address falls in the paged window on page 2
    function automatic logic inPage2(input logic [4:0]  a,
                                     input logic [15:0] pg);
        inPage2 = (a >= PEPCR_PAGED_FIRST) && (a <= PEPCR_PAGED_LAST)
                  && (pg == PEPCR_PAGE_EXT2);
    endfunction

    // Merge written data into a register through a writable mask
    function automatic logic [15:0] mergeMasked(input logic [15:0] old,
                                                input logic [15:0] wd,
                                                input logic [15:0] m);
        mergeMasked = (old & ~m) | (wd & m);
    endfunction

    // ------------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------------

    logic [1:0] statusSync;

    // Link and EEE status come from other clock domains
    pepcr_sync u_status_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .asyncIn ({linkUpPin, eee100Pin}),
        .syncOut (statusSync)
    );

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------

    logic [15:0] page_r;
    logic [15:0] page_nxt;
    logic [15:0] trim_r;
    logic [15:0] trim_nxt;
    logic [15:0] eee_r;
    logic [15:0] eee_nxt;
    logic [15:0] macStk_r;
    logic [15:0] macStk_nxt;
    logic        fastFail_r;
    logic        fastFail_nxt;
    logic [15:0] wake_r;
    logic [15:0] wake_nxt;
    logic [15:0] rdData_r;
    logic [15:0] rdData_nxt;
    logic        wrPaged;

    assign wrPaged = regWr && inPage2(regAddr, page_r);

    // Page selector, written from any page
    always_comb begin
        page_nxt = page_r;
        if (regWr && regAddr == PEPCR_ADDR_PAGE) begin
            page_nxt = regWrData;
        end
    end

    // Sticky registers: only a hardware reset restores them
    always_comb begin
        trim_nxt   = trim_r;
        eee_nxt    = eee_r;
        macStk_nxt = macStk_r;
        wake_nxt   = wake_r;
        if (wrPaged) begin
            unique case (regAddr)
                PEPCR_ADDR_TX_TRIM: begin
                    // Three amplitude trim fields
                    trim_nxt = mergeMasked(trim_r, regWrData,
                                           PEPCR_TRIM_MASK);
                end
                PEPCR_ADDR_EEE_CTL: begin
                    // 10BASE-Te, LED polarity and LPI debug bits
                    eee_nxt = mergeMasked(eee_r, regWrData,
                                          PEPCR_EEE_MASK);
                end
                PEPCR_ADDR_MAC_IF: begin
                    // SOF, reversal and clock delay selects
                    macStk_nxt = mergeMasked(macStk_r, regWrData,
                                             PEPCR_MAC_STK_MASK);
                end
                PEPCR_ADDR_WAKE_LO: begin
                    wake_nxt = mergeMasked(wake_r, regWrData,
                                           PEPCR_WAKE_MASK);
                end
                default: begin
                    // Other paged slots hold nothing here
                end
            endcase
        end
    end

    // Non-sticky fast link fail v2 enable
    always_comb begin
        fastFail_nxt = fastFail_r;
        if (wrPaged && regAddr == PEPCR_ADDR_MAC_IF) begin
            fastFail_nxt = regWrData[PEPCR_MAC_FFAIL_BIT];
        end
    end

    // Hardware reset loads sticky fields with their reset values
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            trim_r   <= PEPCR_TRIM_RST;
            eee_r    <= PEPCR_EEE_RST;
            macStk_r <= PEPCR_MAC_RST;
            wake_r   <= PEPCR_WAKE_RST;
        end else begin
            trim_r   <= trim_nxt;
            eee_r    <= eee_nxt;
            macStk_r <= macStk_nxt;
            wake_r   <= wake_nxt;
        end
    end

    // Either reset clears non-sticky fields and the page
    always_ff @(posedge clk_sys) begin
        if (srst || softRst) begin
            page_r <= PEPCR_PAGE_MAIN;
            fastFail_r <= 1'b0;
        end else begin
            page_r <= page_nxt;
            fastFail_r <= fastFail_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Compose the addressed word; reserved and unmapped read zero
    always_comb begin
        rdData_nxt = PEPCR_ZERO16;
        if (regRd) begin
            if (regAddr == PEPCR_ADDR_PAGE) begin
                rdData_nxt = page_r;
            end else if (inPage2(regAddr, page_r)) begin
                unique case (regAddr)
                    PEPCR_ADDR_TX_TRIM: begin
                        rdData_nxt = trim_r & PEPCR_TRIM_MASK;
                    end
                    PEPCR_ADDR_EEE_CTL: begin
                        rdData_nxt = eee_r & PEPCR_EEE_MASK;
                        rdData_nxt[PEPCR_EEE_LINK_BIT]  = statusSync[1];
                        rdData_nxt[PEPCR_EEE_EN100_BIT] = statusSync[0];
                    end
                    PEPCR_ADDR_MAC_IF: begin
                        rdData_nxt = macStk_r & PEPCR_MAC_STK_MASK;
                        rdData_nxt[PEPCR_MAC_FFAIL_BIT] = fastFail_r;
                    end
                    PEPCR_ADDR_WAKE_LO: begin
                        rdData_nxt = wake_r;
                    end
                    default: begin
                        rdData_nxt = PEPCR_ZERO16;
                    end
                endcase
            end
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdData_r <= PEPCR_ZERO16;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Configuration outputs (direct register slices)
    // ------------------------------------------------------------------

    // Fields handed to the analog and PCS logic
    always_comb begin
        cfg.trimTx100   = trim_r[PEPCR_TRIM_TX100_LSB +: 4];
        cfg.trimT10     = trim_r[PEPCR_TRIM_T10_LSB +: 4];
        cfg.trimTe10    = trim_r[PEPCR_TRIM_TE10_LSB +: 4];
        cfg.eeeTe10En   = eee_r[PEPCR_EEE_TE10_BIT];
        cfg.ledInvert   = eee_r[PEPCR_EEE_LED_LSB +: 2];
        cfg.fastLinkFailV2En = fastFail_r;
        cfg.sofEn       = macStk_r[PEPCR_MAC_SOF_BIT];
        cfg.rxClkDelay  = macStk_r[PEPCR_MAC_RXDLY_LSB +: 3];
        cfg.txClkDelay  = macStk_r[PEPCR_MAC_TXDLY_LSB +: 3];
        cfg.wakeAddrLow = wake_r;
    end

    // ------------------------------------------------------------------
    // Lane handling between MAC and line
    // ------------------------------------------------------------------

    logic        forceLpi;
    logic        inhTxLpi;
    logic        inhRxLpi;
    pepcr_lane_s txGated;
    pepcr_lane_s rxGated;

    assign forceLpi = eee_r[PEPCR_EEE_FLPI_BIT];
    assign inhTxLpi = eee_r[PEPCR_EEE_INHTX_BIT];
    assign inhRxLpi = eee_r[PEPCR_EEE_INHRX_BIT];

    // Transmit: forced LPI overrides MAC data, inhibit blocks MAC LPI
    always_comb begin
        txGated = macTx;
        if (forceLpi) begin
            txGated.lpi  = 1'b1;
            txGated.data = 4'h0;
        end else if (inhTxLpi && speed100) begin
            txGated.lpi  = 1'b0;
        end
    end

    // Receive: inhibit keeps line LPI away from the MAC
    always_comb begin
        rxGated = lineRx;
        if (inhRxLpi && speed100) begin
            rxGated.lpi = 1'b0;
        end
    end

    // Transmit lane register with optional reversal
    pepcr_lane_map u_tx_map (
        .clk_sys (clk_sys),
        .srst    (srst),
        .reverse (macStk_r[PEPCR_MAC_TXREV_BIT]),
        .laneIn  (txGated),
        .laneOut (lineTx)
    );

    // Receive lane register with optional reversal
    pepcr_lane_map u_rx_map (
        .clk_sys (clk_sys),
        .srst    (srst),
        .reverse (macStk_r[PEPCR_MAC_RXREV_BIT]),
        .laneIn  (rxGated),
        .laneOut (macRx)
    );

    assign regRdData = rdData_r;
    assign pageSel   = page_r;

endmodule

// ==== tb/pepcr_regs_chk.sv ====
// Concurrent checks for the extended page 2 register bank
`timescale 1ns/1ns
module pepcr_regs_chk
    import pepcr_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        softRst,
    input wire logic [4:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdData,
    input wire logic        linkUpPin,
    input wire logic        eee100Pin,
    input wire logic        speed100,
    input wire pepcr_lane_s macTx,
    input wire pepcr_lane_s lineRx,
    input wire pepcr_lane_s lineTx,
    input wire pepcr_lane_s macRx,
    input wire pepcr_cfg_s  cfg,
    input wire logic [15:0] pageSel
);
    // ------------------------------------------------------------
    // Shadows of the lane control bits
    // ------------------------------------------------------------
    logic [15:0] eeeSh_r;
    logic [15:0] macSh_r;
    pepcr_lane_s expTx;
    pepcr_lane_s expRx;
    logic        onPage;

    assign onPage = (pageSel == PEPCR_PAGE_EXT2);

    // Follow paged writes to the debug and lane control registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            eeeSh_r <= PEPCR_ZERO16;
            macSh_r <= PEPCR_ZERO16;
        end else if (regWr && onPage) begin
            if (regAddr == PEPCR_ADDR_EEE_CTL) eeeSh_r <= regWrData;
            if (regAddr == PEPCR_ADDR_MAC_IF) macSh_r <= regWrData;
        end
    end

    // Expected lane outputs for the next cycle
    always_comb begin
        expTx = macTx;
        expRx = lineRx;
        if (macSh_r[3]) expTx.data = {<<{macTx.data}};
        if (macSh_r[7]) expRx.data = {<<{lineRx.data}};
        if (eeeSh_r[3] && speed100) expTx.lpi = 1'b0;
        if (eeeSh_r[2] && speed100) expRx.lpi = 1'b0;
        if (eeeSh_r[4]) expTx = '{lpi: 1'b1, data: 4'h0};
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RD_IDLE: assert property (!regRd |=> regRdData == PEPCR_ZERO16)
        else $error("read data not zero outside the read answer");
    AST_TRIM_RST: assert property ($past(srst) |->
        cfg.trimTx100 == 4'h2 && cfg.trimT10 == 4'h8 && cfg.trimTe10 == 4'hE)
        else $error("trim fields not at defaults after reset");
    AST_PAGE_WR: assert property (regWr && !softRst &&
        regAddr == PEPCR_ADDR_PAGE |=> pageSel == $past(regWrData))
        else $error("page register did not take written value");
    AST_SOFT: assert property (softRst && !regWr |=>
        pageSel == PEPCR_ZERO16 && !cfg.fastLinkFailV2En
        && $stable(cfg.wakeAddrLow))
        else $error("soft reset effect wrong");
    AST_OFF_PAGE: assert property (regWr && !onPage && !softRst &&
        regAddr inside {[PEPCR_PAGED_FIRST:PEPCR_PAGED_LAST]} |=> $stable(cfg))
        else $error("write off page changed configuration");
    AST_WAKE_WR: assert property (regWr && onPage &&
        regAddr == PEPCR_ADDR_WAKE_LO |=> cfg.wakeAddrLow == $past(regWrData))
        else $error("wake address low word not written");
    AST_LOW_RD: assert property (regRd &&
        regAddr < PEPCR_PAGED_FIRST |=> regRdData == PEPCR_ZERO16)
        else $error("unpaged register read not zero");
    AST_EEE_RSV: assert property (regRd && onPage &&
        regAddr == PEPCR_ADDR_EEE_CTL |=> (regRdData & 16'h72A3) == 16'h0000)
        else $error("reserved bits of energy control read nonzero");
    AST_TX_LANE: assert property (!$past(srst) |->
        lineTx == $past(expTx))
        else $error("transmit lane mismatch");
    AST_RX_LANE: assert property (!$past(srst) |->
        macRx == $past(expRx))
        else $error("receive lane mismatch");
endmodule

bind pepcr_regs pepcr_regs_chk chk (
    .clk_sys(clk_sys), .srst(srst), .softRst(softRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .linkUpPin(linkUpPin), .eee100Pin(eee100Pin),
    .speed100(speed100), .macTx(macTx), .lineRx(lineRx), .lineTx(lineTx),
    .macRx(macRx), .cfg(cfg), .pageSel(pageSel)
);

// ==== tb/pepcr_mac_model.sv ====
// Behavioural MAC transmit source for the lane path
`timescale 1ns/1ns
module pepcr_mac_model
    import pepcr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire pepcr_lane_s want,
    output pepcr_lane_s      macTx
);
    // Launch each nibble just after the edge and hold it a full cycle
    always_ff @(posedge clk_sys) begin
        macTx <= want;
    end
endmodule

// ==== tb/test_pepcr_regs.sv ====
// Self-checking bench for the extended page 2 register bank
`timescale 1ns/1ns
module test_pepcr_regs
    import pepcr_pkg::*;
;
    logic        clk_sys, srst, softRst, regWr, regRd;
    logic        linkUpPin, eee100Pin, speed100;
    logic [4:0]  regAddr;
    logic [15:0] regWrData, regRdData, pageSel;
    pepcr_lane_s macTx, lineRx, lineTx, macRx, want;
    pepcr_cfg_s  cfg;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;

    pepcr_regs uut (
        .clk_sys(clk_sys), .srst(srst), .softRst(softRst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .linkUpPin(linkUpPin), .eee100Pin(eee100Pin),
        .speed100(speed100), .macTx(macTx), .lineRx(lineRx),
        .lineTx(lineTx), .macRx(macRx), .cfg(cfg), .pageSel(pageSel)
    );
    pepcr_mac_model mac (.clk_sys(clk_sys), .want(want), .macTx(macTx));

    // ------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Cut a hung run short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        chk(regRdData, e);
    endtask

    // Set lane controls, apply one sample each way, compare both lanes
    task automatic lane(input logic [15:0] eee, input logic [15:0] mc,
                        input logic spd, input logic [9:0] io,
                        input logic [9:0] ex);
        wr(PEPCR_ADDR_EEE_CTL, eee);
        wr(PEPCR_ADDR_MAC_IF, mc);
        @(posedge clk_sys);
        speed100 <= spd;
        want <= io[9:5];
        lineRx <= io[4:0];
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({6'h00, lineTx, macRx}, {6'h00, ex});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        softRst = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 5'h00;
        regWrData = 16'h0000;
        linkUpPin = 1'b0;
        eee100Pin = 1'b0;
        speed100 = 1'b1;
        want = 5'h00;
        lineRx = 5'h00;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        wr(PEPCR_ADDR_PAGE, PEPCR_PAGE_EXT2);
        rd(PEPCR_ADDR_PAGE, PEPCR_PAGE_EXT2);
        rd(PEPCR_ADDR_TX_TRIM, 16'h028E);
        rd(PEPCR_ADDR_EEE_CTL, 16'h0000);
        rd(PEPCR_ADDR_MAC_IF, 16'h0000);
        rd(PEPCR_ADDR_WAKE_LO, 16'h0000);
        // All-ones writes leave reserved bits clear
        wr(PEPCR_ADDR_TX_TRIM, 16'hFFFF);
        wr(PEPCR_ADDR_EEE_CTL, 16'hFFFF);
        wr(PEPCR_ADDR_MAC_IF, 16'hFFFF);
        wr(PEPCR_ADDR_WAKE_LO, 16'hFFFF);
        rd(PEPCR_ADDR_TX_TRIM, 16'h0FFF);
        rd(PEPCR_ADDR_EEE_CTL, 16'h8C1C);
        rd(PEPCR_ADDR_MAC_IF, 16'h90FF);
        rd(PEPCR_ADDR_WAKE_LO, 16'hFFFF);
        chk({5'h00, cfg.eeeTe10En, cfg.ledInvert, cfg.fastLinkFailV2En,
             cfg.sofEn, cfg.rxClkDelay, cfg.txClkDelay}, 16'h07FF);
        // Status pins show up after synchronisation
        @(posedge clk_sys);
        linkUpPin <= 1'b1;
        eee100Pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(PEPCR_ADDR_EEE_CTL, 16'h8D5C);
        // Lane handling across the control combinations
        lane(16'h0000, 16'h0000, 1'b1, 10'h232, 10'h232);
        lane(16'h0000, 16'h0088, 1'b1, 10'h023, 10'h10C);
        lane(16'h0010, 16'h0000, 1'b1, 10'h0B2, 10'h212);
        lane(16'h000C, 16'h0000, 1'b1, 10'h232, 10'h022);
        lane(16'h000C, 16'h0000, 1'b0, 10'h232, 10'h232);
        wr(PEPCR_ADDR_EEE_CTL, 16'h0000);
        wr(PEPCR_ADDR_MAC_IF, 16'h90FF);
        // Main page hides the bank
        wr(PEPCR_ADDR_PAGE, PEPCR_PAGE_MAIN);
        wr(PEPCR_ADDR_WAKE_LO, 16'h1234);
        wr(5'h03, 16'hFFFF);
        rd(PEPCR_ADDR_WAKE_LO, 16'h0000);
        rd(5'h03, 16'h0000);
        wr(PEPCR_ADDR_PAGE, PEPCR_PAGE_EXT2);
        rd(PEPCR_ADDR_WAKE_LO, 16'hFFFF);
        rd(5'h12, 16'h0000);
        // Soft reset clears only the non-sticky state
        @(posedge clk_sys);
        softRst <= 1'b1;
        @(posedge clk_sys);
        softRst <= 1'b0;
        @(negedge clk_sys);
        chk(pageSel, PEPCR_PAGE_MAIN);
        wr(PEPCR_ADDR_PAGE, PEPCR_PAGE_EXT2);
        rd(PEPCR_ADDR_MAC_IF, 16'h10FF);
        rd(PEPCR_ADDR_TX_TRIM, 16'h0FFF);
        // Hardware reset returns sticky fields to defaults
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        wr(PEPCR_ADDR_PAGE, PEPCR_PAGE_EXT2);
        rd(PEPCR_ADDR_TX_TRIM, 16'h028E);
        rd(PEPCR_ADDR_WAKE_LO, 16'h0000);
        wrap_up();
    end
endmodule
